// *** logic/clock_reset_generator.sv ***
// Clock select, PLL programming, clock checks, low-power modes and resets
// Operation
// - Doze or stop entered only by software write to low-power control.
// - Stop with pseudo-stop bit set enters pseudo-stop, oscillator kept.
// - Monitor timeout without oscillator edges gives reset or self-clock.
// - Self-clock mode runs the PLL alone at minimum VCO frequency.
// - After power-on or stop wake-up, count oscillator edges in window.
// - Failed quality check gives self-clock with both enables set, clock monitor reset with self-clock off.
// - System reset from power-on, low voltage, watchdog, monitor, pin.
// - Interrupt can be requested when PLL enters or leaves lock.
// - Run keeps all active; doze gates clocks by select bits.
// - Full stop disables oscillator, all clocks, freezes timers.
// - Pseudo-stop keeps oscillator; timers run only with own enable.
// - Self-clock entered only with monitor and self-clock enables set.
// - Self-clock starts quality check, stays until check passes.
// - Reset pin low resets device; device drives it low on reset.
// - Clock-out pin level sampled at reset selects oscillator mode.
// - After reset clock-out pin outputs the system clock.
// - Registers sit at base plus offset, multiplier first, debug last.
// - Multiplier and divider writes ignored while PLL is selected.
// - PLL frequency is 2 times osc times (mult+1) over (div+1).
// - PLL output never below minimum VCO frequency.
// - Multiplier or divider write reinitialises lock and track bits.
// - Lock change sets lock flag; interrupt if lock enable set.
// - Selecting PLL ignored while PLL not locked or tracking.
// - Self-clock status reads one in self-clock mode, else zero.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module clock_reset_generator #(
  parameter int MON_CYC = clock_reset_pkg::MON_TIMEOUT_CYC,
  parameter int CQC_CYC = clock_reset_pkg::CQC_WINDOW_CYC,
  parameter int CQC_MIN = clock_reset_pkg::CQC_EDGES,
  parameter int RST_CYC = clock_reset_pkg::RST_STRETCH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input clock_reset_pkg::regReq_t req,
  output logic [7:0] rdata,
  // Oscillator and PLL analog side
  input wire logic oscClkIn,
  input wire logic pllLockIn,
  input wire logic pllTrackIn,
  output logic oscEnableOut,
  output logic oscLoopModeOut,
  output logic pllPowerOut,
  output logic pllSelfClockOut,
  output logic [7:0] pllNumOut,
  output logic [4:0] pllDenOut,
  output logic pllAutoOut,
  output logic pllAcqOut,
  output logic pllDetInitOut,
  // Clock distribution
  output logic sysClkSelPllOut,
  output logic sysClkEnOut,
  output logic periphClkEnOut,
  output logic rtiClkEnOut,
  output logic wdtClkEnOut,
  output clock_reset_pkg::mode_t modeOut,
  input wire logic wakeIn,
  // Shared clock-out pin
  input wire logic clkOutPinIn,
  output logic clkOutOe,
  // Reset sources and reset pin
  input wire logic porIn,
  input wire logic lvrIn,
  input wire logic wdtTimeoutIn,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic sysResetOut,
  output logic irqOut
);
  import clock_reset_pkg::*;

  // Match a bus address against a register byte offset
  function automatic logic regHit(logic [AW-1:0] a, logic [3:0] idx);
    regHit = (a == {{(AW-4){1'b0}}, idx});
  endfunction : regHit

  // Merge write data into a register under a mask
  function automatic logic [7:0] wMerge(logic [7:0] o, logic [7:0] n,
                                        logic [7:0] m);
    wMerge = (o & ~m) | (n & m);
  endfunction : wMerge

  logic [7:0] multFf, divFf, irqEnFf, clkSelFf, pllCtlFf, lpCtlFf, dbgFf;
  logic stopEfFf, porFf, lvrFf, lockIfFf, lockFf, trackFf, scmIfFf, scmFf;
  mode_t modeFf;
  logic [15:0] monCntFf, cqcCntFf, cqcEdgFf, rstCntFf;
  logic [2:0] guardFf;
  logic cqcActFf, resetnDlyFf;
  logic oscS1, oscS2, oscS3, lockS1, lockS2, trkS1, trkS2;
  logic [1:0] anaS1, anaS2;
  logic pinS1, pinS2, coS1, coS2;

  // Two-stage synchronisers for asynchronous inputs
  always_ff @(posedge clk) begin
    oscS1 <= oscClkIn;
    oscS2 <= oscS1;
    oscS3 <= oscS2;
    lockS1 <= pllLockIn;
    lockS2 <= lockS1;
    trkS1 <= pllTrackIn;
    trkS2 <= trkS1;
    anaS1 <= {lvrIn, porIn};
    anaS2 <= anaS1;
    pinS1 <= resetPinIn;
    pinS2 <= pinS1;
    coS1 <= clkOutPinIn;
    coS2 <= coS1;
  end

  // Register decode
  logic wMult, wDiv, wFlags, wIrqEn, wSel, wPll, wLp, wDbg;
  assign wMult = req.wr && regHit(req.addr, IDX_MULT);
  assign wDiv = req.wr && regHit(req.addr, IDX_DIV);
  assign wFlags = req.wr && regHit(req.addr, IDX_FLAGS);
  assign wIrqEn = req.wr && regHit(req.addr, IDX_IRQEN);
  assign wSel = req.wr && regHit(req.addr, IDX_CLOCK_SOURCE_SELECT);
  assign wPll = req.wr && regHit(req.addr, IDX_PLL_CONTROL);
  assign wLp = req.wr && regHit(req.addr, IDX_LPCTL);
  assign wDbg = req.wr && regHit(req.addr, IDX_DBG);

  // Events shared by several processes
  logic oscEdge, autoEff, pllOk, detInit, monFail, cqcDone, cqcPass;
  logic cqcFail, cmFault, enterScm, leaveScm, cmReset, rstSrc;
  logic stopReq, dozeReq, enterStop, enterDoze, wake, cfgRst, pinLow;
  logic nxtLock, nxtTrack;
  assign oscEdge = oscS2 && !oscS3;
  assign autoEff = pllCtlFf[PC_AUTO] | clkSelFf[SEL_PLLDOZE];
  assign pllOk = autoEff ? lockFf : trackFf;
  assign detInit = (wMult || wDiv) && !clkSelFf[SEL_PLL];
  assign monFail = pllCtlFf[PC_CME] && modeFf != MODE_FSTOP && !scmFf &&
                   monCntFf == 16'(MON_CYC - 1);
  assign cqcDone = cqcActFf && cqcCntFf == 16'(CQC_CYC - 1);
  assign cqcPass = cqcDone && cqcEdgFf >= 16'(CQC_MIN);
  assign cqcFail = cqcDone && !(cqcEdgFf >= 16'(CQC_MIN));
  assign cmFault = monFail || (cqcFail && !scmFf);
  assign enterScm = cmFault && pllCtlFf[PC_SELF_CLOCKING_ENABLE] &&
                    pllCtlFf[PC_CME];
  assign leaveScm = scmFf && cqcPass;
  assign cmReset = cmFault && !pllCtlFf[PC_SELF_CLOCKING_ENABLE];
  assign pinLow = !pinS2 && !resetPinOe && guardFf == 3'h0;
  assign rstSrc = anaS2[0] || anaS2[1] || wdtTimeoutIn ||
                  cmReset || pinLow;
  assign wake = wakeIn && modeFf != MODE_RUN;
  assign stopReq = wLp && req.wdata[LP_STOP];
  assign dozeReq = wLp && req.wdata[LP_DOZE] && !req.wdata[LP_STOP];
  assign enterStop = stopReq && modeFf == MODE_RUN && !wakeIn;
  assign enterDoze = dozeReq && modeFf == MODE_RUN && !wakeIn;
  assign cfgRst = !resetn || sysResetOut;

  // Oscillator mode strap caught just after reset release
  always_ff @(posedge clk) begin
    resetnDlyFf <= resetn;
    if (resetn && !resetnDlyFf) begin
      oscLoopModeOut <= coS2;
    end
  end

  // Multiplier and divider registers
  always_ff @(posedge clk) begin
    if (cfgRst) begin
      multFf <= MULT_RST;
      divFf <= DIV_RST;
    end else begin
      if (wMult && !clkSelFf[SEL_PLL]) begin
        multFf <= req.wdata & MULT_WMASK;
      end
      if (wDiv && !clkSelFf[SEL_PLL]) begin
        divFf <= req.wdata & DIV_WMASK;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (cfgRst) begin
      irqEnFf <= IRQEN_RST;
      clkSelFf <= CLOCK_SOURCE_SELECT_RST;
      pllCtlFf <= PLL_CONTROL_RST;
      dbgFf <= DBG_RST;
    end else begin
      if (wIrqEn) begin
        irqEnFf <= req.wdata & IRQEN_WMASK;
      end
      if (wDbg) begin
        dbgFf <= req.wdata;
      end
      if (wSel) begin
        clkSelFf <= wMerge(clkSelFf, req.wdata, CLOCK_SOURCE_SELECT_WMASK);
        clkSelFf[SEL_PLL] <= req.wdata[SEL_PLL] && pllOk;
      end
      if (enterScm || enterStop ||
          (enterDoze && clkSelFf[SEL_PLLDOZE])) begin
        clkSelFf[SEL_PLL] <= 1'b0;
      end
      if (wPll) begin
        pllCtlFf[5:1] <= req.wdata[5:1];
        if (!scmFf) begin
          pllCtlFf[PC_CME] <= req.wdata[PC_CME];
        end
        if (!clkSelFf[SEL_PLL]) begin
          pllCtlFf[PC_PLLON] <= req.wdata[PC_PLLON];
        end
        pllCtlFf[PC_SELF_CLOCKING_ENABLE] <= req.wdata[PC_SELF_CLOCKING_ENABLE] || scmFf;
      end
    end
  end

  // Operating mode and low-power control
  always_ff @(posedge clk) begin
    if (cfgRst) begin
      modeFf <= MODE_RUN;
      lpCtlFf <= 8'h00;
    end else if (wake) begin
      modeFf <= MODE_RUN;
      lpCtlFf <= 8'h00;
    end else if (enterStop) begin
      modeFf <= clkSelFf[SEL_PSEUDO_STOP_SELECT] ? MODE_PSTOP : MODE_FSTOP;
      lpCtlFf <= 8'h00 | (8'h01 << LP_STOP);
    end else if (enterDoze) begin
      modeFf <= MODE_DOZE;
      lpCtlFf <= 8'h00 | (8'h01 << LP_DOZE);
    end
  end

  // Flags: hardware set wins over a write-one clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stopEfFf <= 1'b0;
      porFf <= 1'b1;
      lvrFf <= 1'b0;
      lockIfFf <= 1'b0;
      scmIfFf <= 1'b0;
    end else begin
      stopEfFf <= enterStop ||
                  (stopEfFf && !(wFlags && req.wdata[FLG_STOP]) && !stopReq);
      porFf <= anaS2[0] || (porFf && !(wFlags && req.wdata[FLG_POR]));
      lvrFf <= anaS2[1] || (lvrFf && !(wFlags && req.wdata[FLG_LVR]));
      lockIfFf <= (lockFf != nxtLock) ||
                  (lockIfFf && !(wFlags && req.wdata[FLG_LOCK_CHANGE_FLAG]));
      scmIfFf <= enterScm || leaveScm ||
                 (scmIfFf && !(wFlags && req.wdata[FLG_SCMIF]));
    end
  end

  // Lock and track status, cleared by detector reinit and in self-clock
  assign nxtLock = lockS2 && !detInit && !scmFf && !enterScm;
  assign nxtTrack = trkS2 && !detInit && !scmFf && !enterScm;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lockFf <= 1'b0;
      trackFf <= 1'b0;
    end else begin
      lockFf <= nxtLock;
      trackFf <= nxtTrack;
    end
  end

  // Self-clock status
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scmFf <= 1'b0;
    end else if (enterScm) begin
      scmFf <= 1'b1;
    end else if (leaveScm) begin
      scmFf <= 1'b0;
    end
  end

  // Clock monitor: counts cycles with no oscillator edge
  always_ff @(posedge clk) begin
    // Held clear in full stop so a stale count cannot mask a later loss
    if (!resetn || oscEdge || monFail || !pllCtlFf[PC_CME] ||
        modeFf == MODE_FSTOP) begin
      monCntFf <= 16'h0000;
    end else begin
      monCntFf <= monCntFf + 16'h0001;
    end
  end

  // Clock quality checker: edges counted over a fixed window
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cqcActFf <= 1'b0;
      cqcCntFf <= 16'h0000;
      cqcEdgFf <= 16'h0000;
    end else if ((!resetnDlyFf) || enterScm || (cqcFail && scmFf) ||
                 (wake && modeFf[1])) begin
      cqcActFf <= 1'b1;
      cqcCntFf <= 16'h0000;
      cqcEdgFf <= 16'h0000;
    end else if (cqcDone) begin
      cqcActFf <= 1'b0;
    end else if (cqcActFf) begin
      cqcCntFf <= cqcCntFf + 16'h0001;
      if (oscEdge && cqcEdgFf != 16'hFFFF) begin
        cqcEdgFf <= cqcEdgFf + 16'h0001;
      end
    end
  end

  // Reset stretch and reset pin drive, with a guard after release
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rstCntFf <= 16'h0000;
      guardFf <= 3'h0;
    end else begin
      if (rstSrc) begin
        rstCntFf <= 16'(RST_CYC);
      end else if (rstCntFf != 16'h0000) begin
        rstCntFf <= rstCntFf - 16'h0001;
      end
      if (resetPinOe) begin
        guardFf <= 3'(PIN_GUARD_CYC);
      end else if (guardFf != 3'h0) begin
        guardFf <= guardFf - 3'h1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sysResetOut <= 1'b0;
      resetPinOut <= 1'b0;
      resetPinOe <= 1'b0;
      irqOut <= 1'b0;
      oscEnableOut <= 1'b1;
      pllPowerOut <= 1'b0;
      pllSelfClockOut <= 1'b0;
      pllNumOut <= 8'h02;
      pllDenOut <= 5'h01;
      pllAutoOut <= 1'b1;
      pllAcqOut <= 1'b0;
      pllDetInitOut <= 1'b0;
      sysClkSelPllOut <= 1'b0;
      sysClkEnOut <= 1'b1;
      periphClkEnOut <= 1'b1;
      rtiClkEnOut <= 1'b1;
      wdtClkEnOut <= 1'b1;
      modeOut <= MODE_RUN;
      clkOutOe <= 1'b0;
      rdata <= 8'h00;
    end else begin
      sysResetOut <= rstCntFf != 16'h0000 || rstSrc;
      resetPinOut <= 1'b0;
      resetPinOe <= rstCntFf != 16'h0000 || rstSrc;
      irqOut <= (lockIfFf && irqEnFf[IE_LOCK]) ||
                (scmIfFf && irqEnFf[IE_SCM]);
      oscEnableOut <= modeFf != MODE_FSTOP;
      pllPowerOut <= scmFf || (pllCtlFf[PC_PLLON] && !modeFf[1] &&
                     !(modeFf == MODE_DOZE && clkSelFf[SEL_PLLDOZE]));
      pllSelfClockOut <= scmFf;
      pllNumOut <= {multFf[5:0], 1'b0} + 8'h02;
      pllDenOut <= {1'b0, divFf[3:0]} + 5'h01;
      pllAutoOut <= autoEff;
      pllAcqOut <= pllCtlFf[PC_ACQ];
      pllDetInitOut <= detInit;
      sysClkSelPllOut <= clkSelFf[SEL_PLL] && !scmFf;
      sysClkEnOut <= modeFf == MODE_RUN;
      periphClkEnOut <= modeFf == MODE_RUN ||
                        modeFf == MODE_DOZE;
      rtiClkEnOut <= modeFf == MODE_RUN ||
                     (modeFf == MODE_DOZE && !clkSelFf[SEL_RTIDOZE]) ||
                     (modeFf == MODE_PSTOP && pllCtlFf[PC_RTIPS]);
      wdtClkEnOut <= modeFf == MODE_RUN ||
                     (modeFf == MODE_DOZE && !clkSelFf[SEL_WDTDOZE]) ||
                     (modeFf == MODE_PSTOP && pllCtlFf[PC_WDTPS]);
      modeOut <= modeFf;
      clkOutOe <= resetnDlyFf;
      rdata <= 8'h00;
      if (req.rd) begin
        case (req.addr[3:0])
          IDX_MULT: rdata <= multFf;
          IDX_DIV: rdata <= divFf;
          IDX_FLAGS: rdata <= {stopEfFf, porFf, lvrFf, lockIfFf,
                               lockFf, trackFf, scmIfFf, scmFf};
          IDX_IRQEN: rdata <= irqEnFf;
          IDX_CLOCK_SOURCE_SELECT: rdata <= clkSelFf;
          IDX_PLL_CONTROL: rdata <= pllCtlFf;
          IDX_LPCTL: rdata <= lpCtlFf;
          IDX_DBG: rdata <= dbgFf;
          default: rdata <= 8'h00;
        endcase
        if (req.addr[AW-1:4] != '0) begin
          rdata <= 8'h00;
        end
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn || sysResetOut);

  sequence stopWritePseudo;
    stopReq && modeFf == MODE_RUN && !wakeIn && clkSelFf[SEL_PSEUDO_STOP_SELECT];
  endsequence
  sequence pseudoHeld;
    modeFf == MODE_PSTOP ##1 oscEnableOut;
  endsequence

  a_mult_locked: assert property (
    wMult && clkSelFf[SEL_PLL] |=> $stable(multFf))
    else $error("multiplier changed while PLL selected");
  a_pll_source_select_guard: assert property (
    wSel && req.wdata[SEL_PLL] && !pllOk |=> !clkSelFf[SEL_PLL])
    else $error("PLL selected while unstable");
  a_det_reinit: assert property (
    detInit |=> !lockFf && !trackFf && pllDetInitOut)
    else $error("lock detector not reinitialised");
  a_lock_flag: assert property (
    $changed(lockFf) && !wFlags |-> lockIfFf)
    else $error("lock change not flagged");
  a_scm_entry: assert property (
    $rose(scmFf) |-> $past(pllCtlFf[PC_CME] && pllCtlFf[PC_SELF_CLOCKING_ENABLE]))
    else $error("self-clock entered without enables");
  a_scm_check: assert property (
    enterScm |=> scmFf && cqcActFf ##1 pllSelfClockOut)
    else $error("self-clock entry without quality check");
  a_pseudo_stop: assert property (
    stopWritePseudo |=> pseudoHeld)
    else $error("pseudo-stop not entered");
  a_full_stop: assert property (
    modeFf == MODE_FSTOP |=> !oscEnableOut && !rtiClkEnOut &&
                              !wdtClkEnOut && !sysClkEnOut)
    else $error("clocks running in full stop");
  a_reset_drive: assert property (
    cmReset |=> sysResetOut && resetPinOe)
    else $error("monitor reset not driven on pin");
  a_no_lowpower: assert property (
    $past(modeFf) == MODE_RUN && modeFf != MODE_RUN |->
      $past(wLp))
    else $error("low-power mode without software write");
  a_unused_read: assert property (
    req.rd && regHit(req.addr, IDX_UNUSED) |=> rdata == 8'h00)
    else $error("unused offset read nonzero");
endmodule : clock_reset_generator

// *** logic/clock_reset_pkg.sv ***
// Shared constants, types and register map of the clock and reset unit
package clock_reset_pkg;
  localparam int AW = 6;
  // Register byte offsets from the unit base address
  localparam logic [3:0] IDX_MULT = 4'h0;
  localparam logic [3:0] IDX_DIV = 4'h1;
  localparam logic [3:0] IDX_UNUSED = 4'h2;
  localparam logic [3:0] IDX_FLAGS = 4'h3;
  localparam logic [3:0] IDX_IRQEN = 4'h4;
  localparam logic [3:0] IDX_CLOCK_SOURCE_SELECT = 4'h5;
  localparam logic [3:0] IDX_PLL_CONTROL = 4'h6;
  localparam logic [3:0] IDX_LPCTL = 4'h7;
  localparam logic [3:0] IDX_DBG = 4'h8;
  // Values after reset
  localparam logic [7:0] MULT_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] IRQEN_RST = 8'h00;
  localparam logic [7:0] CLOCK_SOURCE_SELECT_RST = 8'h00;
  localparam logic [7:0] PLL_CONTROL_RST = 8'h81;
  localparam logic [7:0] DBG_RST = 8'h00;
  // Writable bits
  localparam logic [7:0] MULT_WMASK = 8'h3F;
  localparam logic [7:0] DIV_WMASK = 8'h0F;
  localparam logic [7:0] IRQEN_WMASK = 8'h12;
  localparam logic [7:0] CLOCK_SOURCE_SELECT_WMASK = 8'h4B;
  // Field positions
  localparam int FLG_STOP = 7, FLG_POR = 6, FLG_LVR = 5, FLG_LOCK_CHANGE_FLAG = 4;
  localparam int FLG_LOCK = 3, FLG_TRACK = 2, FLG_SCMIF = 1, FLG_SCM = 0;
  localparam int IE_LOCK = 4, IE_SCM = 1;
  localparam int SEL_PLL = 7, SEL_PSEUDO_STOP_SELECT = 6, SEL_PLLDOZE = 3;
  localparam int SEL_RTIDOZE = 1, SEL_WDTDOZE = 0;
  localparam int PC_CME = 7, PC_PLLON = 6, PC_AUTO = 5, PC_ACQ = 4;
  localparam int PC_RTIPS = 2, PC_WDTPS = 1, PC_SELF_CLOCKING_ENABLE = 0;
  localparam int LP_STOP = 1, LP_DOZE = 0;
  // Timing
  localparam int CLK_NS = 10;
  localparam int MON_TIMEOUT_NS = 500;
  localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CQC_WINDOW_NS = 2000;
  localparam int CQC_WINDOW_CYC = (CQC_WINDOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CQC_EDGES = 64;
  localparam int RST_STRETCH_NS = 640;
  localparam int RST_STRETCH_CYC = (RST_STRETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIN_GUARD_CYC = 4;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00, MODE_DOZE = 2'b01,
    MODE_FSTOP = 2'b10, MODE_PSTOP = 2'b11
  } mode_t;
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } regReq_t;
endpackage : clock_reset_pkg

// *** verif/osc_pll_model.sv ***
// Behavioural model of the oscillator and PLL analog side
`timescale 1ns/1ps
module osc_pll_model (
  // Controls from the clock unit
  input wire logic clk,
  input wire logic oscEnable,
  input wire logic pllPower,
  input wire logic selfClock,
  input wire logic detInit,
  // Bench control: crystal failure
  input wire logic kill,
  // Analog outputs
  output logic oscillator_clock,
  output logic pllLock,
  output logic pllTrack
);
  int lockCnt;
  // Crystal runs at a quarter of the bus clock; static when halted
  initial oscillator_clock = 1'b0;
  always begin
    #20;
    oscillator_clock = (oscEnable && !kill) ? ~oscillator_clock : 1'b0;
  end
  // Lock and track after settling; detector restart drops both
  always_ff @(posedge clk) begin
    if (!pllPower || selfClock || detInit) lockCnt <= 0;
    else if (lockCnt < 12) lockCnt <= lockCnt + 1;
  end
  assign pllLock = (lockCnt >= 12);
  assign pllTrack = pllLock;
endmodule : osc_pll_model

// *** verif/tb_clock_reset_generator.sv ***
// Self-checking bench for the clock and reset generator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); \
  end \
end
`define WAIT(c, n) for (int k = 0; k < (n) && !(c); k++) begin \
  @(posedge clk); \
  #1; \
end
module tb_clock_reset_generator;
  import clock_reset_pkg::*;
  logic clk, resetn, oscClkIn, pllLockIn, pllTrackIn, oscEnableOut;
  logic oscLoopModeOut, pllPowerOut, pllSelfClockOut, pllAutoOut;
  logic pllAcqOut, pllDetInitOut, sysClkSelPllOut, sysClkEnOut;
  logic periphClkEnOut, rtiClkEnOut, wdtClkEnOut, wakeIn, clkOutPinIn;
  logic clkOutOe, porIn, lvrIn, wdtTimeoutIn, resetPinIn, resetPinOut;
  logic resetPinOe, sysResetOut, irqOut, extPin, strap, kill;
  logic [7:0] rdata, pllNumOut, rv;
  logic [4:0] pllDenOut;
  regReq_t req;
  mode_t modeOut;
  int n_fail, check_count, cyc;

  // Shared pins: open-drain reset with pull-up, strap until clock-out
  assign resetPinIn = resetPinOe ? resetPinOut : extPin;
  assign clkOutPinIn = clkOutOe ? clk : strap;

  clock_reset_generator #(.MON_CYC(8), .CQC_CYC(20), .CQC_MIN(4),
    .RST_CYC(4)) dut (.clk, .resetn, .req, .rdata, .oscClkIn, .pllLockIn,
    .pllTrackIn, .oscEnableOut, .oscLoopModeOut, .pllPowerOut,
    .pllSelfClockOut, .pllNumOut, .pllDenOut, .pllAutoOut, .pllAcqOut,
    .pllDetInitOut, .sysClkSelPllOut, .sysClkEnOut, .periphClkEnOut,
    .rtiClkEnOut, .wdtClkEnOut, .modeOut, .wakeIn, .clkOutPinIn,
    .clkOutOe, .porIn, .lvrIn, .wdtTimeoutIn, .resetPinIn, .resetPinOut,
    .resetPinOe, .sysResetOut, .irqOut);

  osc_pll_model model (.clk, .oscEnable(oscEnableOut),
    .pllPower(pllPowerOut), .selfClock(pllSelfClockOut),
    .detInit(pllDetInitOut), .kill, .oscillator_clock(oscClkIn),
    .pllLock(pllLockIn), .pllTrack(pllTrackIn));

  // Bus clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One-cycle write strobe
  task automatic regWr(input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: AW'(idx), wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : regWr
  // One-cycle read strobe, data taken in the following cycle
  task automatic regRd(input logic [3:0] idx, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: AW'(idx), wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : regRd
  task automatic chkRd(input logic [3:0] idx, input logic [7:0] e,
                       input string nm);
    regRd(idx, rv);
    `CHK(nm, e, rv)
  endtask : chkRd
  task automatic wake();
    @(posedge clk);
    wakeIn <= 1'b1;
    @(posedge clk);
    wakeIn <= 1'b0;
    tick(3);
  endtask : wake

  // Values after reset, strap, unused and unmapped places
  task automatic t_reset();
    tick(20);
    `CHK("mode", MODE_RUN, modeOut)
    `CHK("strap", 1'b1, oscLoopModeOut)
    `CHK("clkout", 1'b1, clkOutOe)
    `CHK("num", 8'h02, pllNumOut)
    chkRd(IDX_PLL_CONTROL, 8'h81, "pll_control");
    regWr(IDX_UNUSED, 8'hFF);
    chkRd(IDX_UNUSED, 8'h00, "unused");
    chkRd(4'hA, 8'h00, "unmapped");
    chkRd(IDX_FLAGS, 8'h40, "flags");
  endtask : t_reset

  // Multiplier and divider reach the PLL, detector restarted
  task automatic t_ratio();
    regWr(IDX_MULT, 8'h05);
    #1;
    `CHK("detinit", 1'b1, pllDetInitOut)
    tick(1);
    `CHK("num", 8'h0C, pllNumOut)
    regWr(IDX_DIV, 8'hF3);
    tick(2);
    `CHK("den", 5'h04, pllDenOut)
    regWr(IDX_MULT, 8'hFF);
    chkRd(IDX_MULT, 8'h3F, "mult");
    `CHK("num", 8'h80, pllNumOut)
  endtask : t_ratio

  // Lock flag, interrupt, guarded select and locked ratio
  task automatic t_lock();
    // Unity overall ratio keeps the system clock within its maximum
    regWr(IDX_MULT, 8'h01);
    regWr(IDX_PLL_CONTROL, 8'hE1);
    regWr(IDX_CLOCK_SOURCE_SELECT, 8'h80);
    chkRd(IDX_CLOCK_SOURCE_SELECT, 8'h00, "clock_source_select");
    tick(40);
    chkRd(IDX_FLAGS, 8'h5C, "flags");
    regWr(IDX_IRQEN, 8'h10);
    tick(2);
    `CHK("irq", 1'b1, irqOut)
    regWr(IDX_FLAGS, 8'h10);
    tick(2);
    `CHK("irq", 1'b0, irqOut)
    regWr(IDX_CLOCK_SOURCE_SELECT, 8'h80);
    tick(2);
    `CHK("selpll", 1'b1, sysClkSelPllOut)
    `CHK("pllpow", 1'b1, pllPowerOut)
    `CHK("auto", 1'b1, pllAutoOut)
    `CHK("acq", 1'b0, pllAcqOut)
    regWr(IDX_MULT, 8'h07);
    chkRd(IDX_MULT, 8'h01, "mult");
    regWr(IDX_DIV, 8'h07);
    chkRd(IDX_DIV, 8'h03, "div");
    regWr(IDX_CLOCK_SOURCE_SELECT, 8'h00);
    regWr(IDX_IRQEN, 8'h00);
  endtask : t_lock

  // Doze, pseudo-stop and full stop with their clock gates
  task automatic t_lowpower();
    regWr(IDX_CLOCK_SOURCE_SELECT, 8'h02);
    regWr(IDX_LPCTL, 8'h01);
    tick(3);
    `CHK("mode", MODE_DOZE, modeOut)
    `CHK("rti", 1'b0, rtiClkEnOut)
    `CHK("wdt", 1'b1, wdtClkEnOut)
    `CHK("periph", 1'b1, periphClkEnOut)
    wake();
    `CHK("mode", MODE_RUN, modeOut)
    regWr(IDX_CLOCK_SOURCE_SELECT, 8'h40);
    regWr(IDX_PLL_CONTROL, 8'hE3);
    regWr(IDX_LPCTL, 8'h02);
    tick(3);
    `CHK("mode", MODE_PSTOP, modeOut)
    `CHK("osc", 1'b1, oscEnableOut)
    `CHK("wdt", 1'b1, wdtClkEnOut)
    `CHK("rti", 1'b0, rtiClkEnOut)
    `CHK("periph", 1'b0, periphClkEnOut)
    wake();
    regWr(IDX_CLOCK_SOURCE_SELECT, 8'h00);
    regWr(IDX_LPCTL, 8'h02);
    tick(3);
    `CHK("mode", MODE_FSTOP, modeOut)
    `CHK("osc", 1'b0, oscEnableOut)
    `CHK("sys", 1'b0, sysClkEnOut)
    `CHK("wdt", 1'b0, wdtClkEnOut)
    `CHK("pllpow", 1'b0, pllPowerOut)
    wake();
    tick(60);
    `CHK("osc", 1'b1, oscEnableOut)
    `CHK("selfclk", 1'b0, pllSelfClockOut)
  endtask : t_lowpower

  // Crystal loss with self-clock enabled, then recovery
  task automatic t_selfclock();
    @(posedge clk) kill <= 1'b1;
    `WAIT(pllSelfClockOut === 1'b1, 40)
    `CHK("selfclk", 1'b1, pllSelfClockOut)
    `CHK("sysrst", 1'b0, sysResetOut)
    regRd(IDX_FLAGS, rv);
    `CHK("scm", 1'b1, rv[0])
    tick(50);
    `CHK("selfclk", 1'b1, pllSelfClockOut)
    @(posedge clk) kill <= 1'b0;
    `WAIT(pllSelfClockOut === 1'b0, 100)
    `CHK("selfclk", 1'b0, pllSelfClockOut)
    regRd(IDX_FLAGS, rv);
    `CHK("scm", 1'b0, rv[0])
  endtask : t_selfclock

  // Crystal loss with self-clock disabled gives a system reset
  task automatic t_monreset();
    regWr(IDX_PLL_CONTROL, 8'h80);
    @(posedge clk) kill <= 1'b1;
    `WAIT(sysResetOut === 1'b1, 40)
    `CHK("sysrst", 1'b1, sysResetOut)
    `CHK("selfclk", 1'b0, pllSelfClockOut)
    @(posedge clk) kill <= 1'b0;
    `WAIT(sysResetOut === 1'b0, 100)
    tick(40);
    chkRd(IDX_PLL_CONTROL, 8'h81, "pll_control");
  endtask : t_monreset

  // Power-on, low voltage, watchdog and pin each reset the system
  task automatic t_sources();
    regWr(IDX_FLAGS, 8'hE0);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      porIn <= (s == 0);
      lvrIn <= (s == 1);
      wdtTimeoutIn <= (s == 2);
      extPin <= (s != 3);
      repeat (3) @(posedge clk);
      {porIn, lvrIn, wdtTimeoutIn, extPin} <= 4'h1;
      `WAIT(sysResetOut === 1'b1, 10)
      `CHK("sysrst", 1'b1, sysResetOut)
      `CHK("pinoe", 1'b1, resetPinOe)
      `CHK("pinout", 1'b0, resetPinOut)
      `WAIT(sysResetOut === 1'b0, 40)
      `CHK("sysrst", 1'b0, sysResetOut)
      tick(40);
    end
    regRd(IDX_FLAGS, rv);
    `CHK("flags", 2'b11, rv[6:5])
  endtask : t_sources

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    {resetn, wakeIn, porIn, lvrIn, wdtTimeoutIn, kill} = 6'h00;
    {extPin, strap} = 2'b11;
    req = '0;
    {cyc, n_fail, check_count} = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_ratio();
    t_lock();
    t_lowpower();
    t_selfclock();
    t_monreset();
    t_sources();
    finish_test();
  end
endmodule : tb_clock_reset_generator
